// [logic/ppce_pkg.sv]
// package: register map, reset values and pin masks of the port block
package ppce_pkg;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned PINS   = 8;

  // register offsets
  localparam logic [9:0] OFS_DATA  = 10'h290;
  localparam logic [9:0] OFS_DIR   = 10'h291;
  localparam logic [9:0] OFS_PULL  = 10'h292;
  localparam logic [9:0] OFS_POL   = 10'h293;
  localparam logic [9:0] OFS_OD    = 10'h294;
  localparam logic [9:0] OFS_IE    = 10'h295;
  localparam logic [9:0] OFS_FLAG  = 10'h296;
  localparam logic [9:0] OFS_PIN   = 10'h297;
  localparam logic [9:0] OFS_DIEN  = 10'h299;

  // reset values
  localparam logic [7:0] RST_DATA  = 8'h00;
  localparam logic [7:0] RST_DIR   = 8'h00;
  localparam logic [7:0] RST_PULL  = 8'h00;
  localparam logic [7:0] RST_POL   = 8'h00;
  localparam logic [7:0] RST_OD    = 8'h00;
  localparam logic [7:0] RST_IE    = 8'h00;
  localparam logic [7:0] RST_FLAG  = 8'h00;
  localparam logic [7:0] RST_DIEN  = 8'h00;

  // pins tied to shared controllers
  localparam logic [7:0] CAN_RX_MASK = 8'h01;
  localparam logic [7:0] I2C_MASK    = 8'hC0;

  // input synchroniser depth, also the stale-read window
  localparam int unsigned SYNC_CYC = 2;
endpackage : ppce_pkg

// [logic/ppce_port.sv]
// module: one eight-pin port with pin configuration and edge interrupts
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - direction bit one output, zero input
// - pin reads lag two cycles after direction
// - enabled peripheral overrides, higher rank wins
// - input enable one turns input buffer on
// - pull enable activates pull on input/open-drain
// - push-pull output never has a pull
// - open-drain output allows pullup only
// - polarity one pulldown/rising, zero pullup/falling
// - active can pin: pulldown request disables pull
// - open-drain bit drives low only
// - open-drain bit ignored on input pins
// - i2c enable forces its pins open-drain
// - interrupt enable gates flag onto request
// - edges detected in input and output mode
// - active edge sets flag, writing one clears
module ppce_port
  import ppce_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [7:0]        regRdData,
  // higher ranked shared peripheral
  input  wire logic [7:0]        hiEn,
  input  wire logic [7:0]        hiOe,
  input  wire logic [7:0]        hiOut,
  // lower ranked shared peripheral
  input  wire logic [7:0]        loEn,
  input  wire logic [7:0]        loOe,
  input  wire logic [7:0]        loOut,
  // controller enables
  input  wire logic              canActive,
  input  wire logic              i2cEn,
  // pads
  input  wire logic [7:0]        padIn,
  output logic      [7:0]        padOut,
  output logic      [7:0]        padOe,
  output logic      [7:0]        pullUpEn,
  output logic      [7:0]        pullDnEn,
  output logic      [7:0]        inBufEn,
  output logic      [7:0]        pinSync,
  // interrupt
  output logic                   irq
);

  typedef struct packed {
    logic [7:0] dat;
    logic [7:0] dir;
    logic [7:0] pull;
    logic [7:0] pol;
    logic [7:0] od;
    logic [7:0] ie;
    logic [7:0] flag;
    logic [7:0] dien;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] rd;
    logic [7:0] pOut;
    logic [7:0] pOe;
    logic [7:0] pu;
    logic [7:0] pd;
    logic       irq;
  } ppce_state_s;

  ppce_state_s st_r;
  ppce_state_s st_nxt;

  function automatic logic [7:0] ppce_pick(input logic [7:0] hiE,
                                           input logic [7:0] hiV,
                                           input logic [7:0] loE,
                                           input logic [7:0] loV,
                                           input logic [7:0] gpV);
    ppce_pick = (hiE & hiV) | (~hiE & loE & loV) | (~hiE & ~loE & gpV);
  endfunction : ppce_pick

  logic [7:0] effOe;
  logic [7:0] effOut;
  logic [7:0] odEff;
  logic [7:0] ppDrv;
  logic [7:0] odDrv;
  logic [7:0] pullAct;
  logic [7:0] edgeHit;
  logic [7:0] clrMask;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    // peripheral ownership before gpio settings
    effOe  = ppce_pick(hiEn, hiOe, loEn, loOe, st_r.dir);
    effOut = ppce_pick(hiEn, hiOut, loEn, loOut, st_r.dat);
    odEff  = st_r.od | (i2cEn ? I2C_MASK : 8'h00);
    ppDrv  = effOe & ~odEff;
    odDrv  = effOe & odEff;
    pullAct = st_r.pull & ~ppDrv;
    st_nxt.pOut = effOut & ppDrv;
    st_nxt.pOe  = ppDrv | (odDrv & ~effOut);
    st_nxt.pu   = pullAct & ~st_r.pol;
    st_nxt.pd   = pullAct & st_r.pol & ~odDrv
                & ~(canActive ? CAN_RX_MASK : 8'h00);
    // disabled input buffer reads low, keeping analog pins quiet
    st_nxt.s1 = padIn & st_r.dien;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // pad is sampled whatever drives it
    edgeHit = (st_r.pol & st_r.s2 & ~st_r.s3)
            | (~st_r.pol & ~st_r.s2 & st_r.s3);
    clrMask = 8'h00;
    if (regWrEn) begin
      case (regAddr)
        OFS_DATA: st_nxt.dat  = regWrData;
        OFS_DIR:  st_nxt.dir  = regWrData;
        OFS_PULL: st_nxt.pull = regWrData;
        OFS_POL:  st_nxt.pol  = regWrData;
        OFS_OD:   st_nxt.od   = regWrData;
        OFS_IE:   st_nxt.ie   = regWrData;
        OFS_FLAG: clrMask     = regWrData;
        OFS_DIEN: st_nxt.dien = regWrData;
        default:  clrMask     = 8'h00;
      endcase
    end
    // a new edge beats a clear in the same cycle
    st_nxt.flag = (st_r.flag & ~clrMask) | edgeHit;
    st_nxt.irq  = |(st_nxt.flag & st_r.ie);
    st_nxt.rd = 8'h00;
    if (regRdEn) begin
      case (regAddr)
        OFS_DATA: st_nxt.rd = (st_r.dir & st_r.dat) | (~st_r.dir & st_r.s2);
        OFS_DIR:  st_nxt.rd = st_r.dir;
        OFS_PULL: st_nxt.rd = st_r.pull;
        OFS_POL:  st_nxt.rd = st_r.pol;
        OFS_OD:   st_nxt.rd = st_r.od;
        OFS_IE:   st_nxt.rd = st_r.ie;
        OFS_FLAG: st_nxt.rd = st_r.flag;
        OFS_PIN:  st_nxt.rd = st_r.s2;
        OFS_DIEN: st_nxt.rd = st_r.dien;
        default:  st_nxt.rd = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_r      <= '0;
      st_r.dat  <= RST_DATA;
      st_r.dir  <= RST_DIR;
      st_r.pull <= RST_PULL;
      st_r.pol  <= RST_POL;
      st_r.od   <= RST_OD;
      st_r.ie   <= RST_IE;
      st_r.flag <= RST_FLAG;
      st_r.dien <= RST_DIEN;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rd;
  assign padOut    = st_r.pOut;
  assign padOe     = st_r.pOe;
  assign pullUpEn  = st_r.pu;
  assign pullDnEn  = st_r.pd;
  assign inBufEn   = st_r.dien;
  assign pinSync   = st_r.s2;
  assign irq       = st_r.irq;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_dir_drives: assert property (
    (regWrEn && regAddr == OFS_DIR && hiEn == 8'h00 && loEn == 8'h00
     && !i2cEn && st_r.od == 8'h00)
    ##1 (hiEn == 8'h00 && loEn == 8'h00 && !i2cEn && st_r.od == 8'h00)
    |=> (padOe == $past(regWrData, 2)))
    else $error("direction write not reflected on output enable");

  chk_sync_lag: assert property (
    (st_r.dien == 8'hFF && $stable(st_r.dien)) ##0 1 ##1 $stable(st_r.dien)
    |-> pinSync == $past(padIn, 2))
    else $error("pin sample does not lag pad by two cycles");

  chk_hi_priority: assert property (
    (hiEn == 8'hFF && !i2cEn && st_r.od == 8'h00) |=> padOe == $past(hiOe))
    else $error("higher ranked peripheral did not own the pins");

  chk_pp_nopull: assert property (
    ##1 ((padOe & padOut) & (pullUpEn | pullDnEn)) == 8'h00)
    else $error("pull active on driven high push-pull pin");

  chk_od_nopulldn: assert property (
    (st_r.od == 8'hFF) |=> ((padOe & pullDnEn) == 8'h00))
    else $error("pulldown active on open-drain output");

  chk_can_pull: assert property (
    (canActive && st_r.pol[0]) |=> !pullDnEn[0] && !pullUpEn[0])
    else $error("pull left on at can receive pin");

  chk_od_high: assert property (
    ##1 ((padOut & $past(st_r.od)) == 8'h00))
    else $error("open-drain pin driven high");

  chk_flag_set: assert property (
    (st_r.pol[0] && st_r.s2[0] && !st_r.s3[0]) |=> st_r.flag[0])
    else $error("active edge did not set flag");

  chk_flag_clear: assert property (
    (regWrEn && regAddr == OFS_FLAG && regWrData[0] && st_r.flag[0]
     && !(st_r.pol[0] ? (st_r.s2[0] && !st_r.s3[0]) : (!st_r.s2[0] && st_r.s3[0])))
    |=> !st_r.flag[0])
    else $error("write one did not clear flag");

  chk_irq_level: assert property (
    ##1 (irq == |(st_r.flag & $past(st_r.ie))))
    else $error("interrupt does not follow enabled flags");

  cov_edge_irq: cover property (st_r.flag[0] && st_r.ie[0] ##1 irq);
  cov_i2c_od:   cover property (i2cEn && (st_r.pOe & I2C_MASK) != 8'h00);
  cov_set_clr:  cover property (regWrEn && regAddr == OFS_FLAG && |edgeHit);
endmodule : ppce_port

// [tb/ppce_pads.sv]
// pad model: resolves each pin level from port drive, pulls and an outside driver
`timescale 1ns/100ps
module ppce_pads (
  // clock
  input  wire logic       sys_clk,
  // from the port
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] pullUpEn,
  input  wire logic [7:0] pullDnEn,
  // outside driver
  input  wire logic [7:0] extEn,
  input  wire logic [7:0] extVal,
  // resolved level
  output logic      [7:0] padIn
);
  initial padIn = 8'h00;
  // floating pins toggle so a stale level never passes for a drive
  always @(posedge sys_clk) begin
    for (int i = 0; i < 8; i++) begin
      padIn[i] <= padOe[i] ? padOut[i] : extEn[i] ? extVal[i] :
                  pullUpEn[i] ? 1'b1 : pullDnEn[i] ? 1'b0 : ~padIn[i];
    end
  end
endmodule : ppce_pads

// [tb/ppce_port_tb_top.sv]
// bench: register, pad and interrupt tests of the port block
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("FAIL %0t got %h want %h", $time, a, b); end end
module ppce_port_tb_top
  import ppce_pkg::*;
;
  logic       sys_clk = 1'b0, rst_b = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, irq;
  logic       canActive = 1'b0, i2cEn = 1'b0;
  logic [9:0] regAddr = 10'h000;
  logic [7:0] regWrData = 8'h00, regRdData, padIn, padOut, padOe, pullUpEn, pullDnEn;
  logic [7:0] hiEn = 8'h00, hiOe = 8'h00, hiOut = 8'h00, loEn = 8'h00, loOe = 8'h00;
  logic [7:0] loOut = 8'h00, extEn = 8'hFF, extVal = 8'h00, inBufEn, pinSync;
  logic [9:0] ofs [6] = '{OFS_DIR, OFS_PULL, OFS_POL, OFS_OD, OFS_IE, OFS_DIEN};
  int         n_mismatch = 0, tests_run = 0;
  ppce_port ppce_port_inst (.sys_clk, .rst_b, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .hiEn, .hiOe, .hiOut, .loEn, .loOe, .loOut, .canActive, .i2cEn, .padIn,
    .padOut, .padOe, .pullUpEn, .pullDnEn, .inBufEn, .pinSync, .irq);
  ppce_pads ppce_pads_inst (.sys_clk, .padOut, .padOe, .pullUpEn, .pullDnEn, .extEn,
    .extVal, .padIn);
  initial forever #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge sys_clk);
    regWrEn   <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 `CHK(regRdData, e)
  endtask : rdc
  // outputs are registered one cycle behind config, pads one more
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic stop_test();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial begin
    #100us;
    n_mismatch++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 'h290; a <= 'h299; a++) rdc(10'(a), 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], 8'hA5);
      rdc(ofs[i], 8'hA5);
      wr(ofs[i], 8'h00);
    end
    wr(10'h298, 8'hFF);
    rdc(10'h298, 8'h00);
    $display("test registers done");
    wr(OFS_DATA, 8'hA5);
    wr(OFS_DIR, 8'hFF);
    wr(OFS_PULL, 8'hFF);
    settle();
    `CHK(padOe, 8'hFF)
    `CHK(padOut, 8'hA5)
    `CHK(pullUpEn | pullDnEn, 8'h00)
    wr(OFS_OD, 8'hFF);
    settle();
    `CHK(padOe, 8'h5A)
    `CHK(padOut, 8'h00)
    `CHK(pullUpEn, 8'hFF)
    wr(OFS_POL, 8'hFF);
    settle();
    `CHK(pullUpEn | pullDnEn, 8'h00)
    wr(OFS_DIR, 8'h00);
    settle();
    `CHK(padOe, 8'h00)
    `CHK(pullDnEn, 8'hFF)
    $display("test drive and pulls done");
    wr(OFS_OD, 8'h00);
    hiEn  <= 8'h0F;
    hiOe  <= 8'h0F;
    hiOut <= 8'h05;
    loEn  <= 8'hFF;
    loOe  <= 8'hFF;
    loOut <= 8'hF0;
    settle();
    `CHK(padOe, 8'hFF)
    `CHK(padOut, 8'hF5)
    hiEn  <= 8'h00;
    loEn  <= 8'h00;
    i2cEn <= 1'b1;
    wr(OFS_DATA, 8'h40);
    wr(OFS_DIR, 8'hFF);
    settle();
    `CHK(padOe, 8'hBF)
    `CHK(padOut, 8'h00)
    i2cEn     <= 1'b0;
    canActive <= 1'b1;
    wr(OFS_DIR, 8'h00);
    wr(OFS_PULL, 8'h01);
    wr(OFS_POL, 8'h01);
    settle();
    `CHK(pullUpEn[0] | pullDnEn[0], 1'b0)
    $display("test sharing done");
    canActive <= 1'b0;
    extVal    <= 8'h02;
    wr(OFS_DATA, 8'h04);
    wr(OFS_DIR, 8'h04);
    wr(OFS_IE, 8'h07);
    wr(OFS_DIEN, 8'hFF);
    settle();
    `CHK(inBufEn, 8'hFF)
    wr(OFS_FLAG, 8'hFF);
    rdc(OFS_FLAG, 8'h00);
    rdc(OFS_PIN, 8'h06);
    extVal <= 8'h01;
    wr(OFS_DATA, 8'h00);
    settle();
    rdc(OFS_FLAG, 8'h07);
    `CHK(irq, 1'b1)
    wr(OFS_IE, 8'h00);
    settle();
    `CHK(irq, 1'b0)
    wr(OFS_IE, 8'h07);
    wr(OFS_FLAG, 8'h07);
    settle();
    rdc(OFS_FLAG, 8'h00);
    `CHK(irq, 1'b0)
    wr(OFS_DIEN, 8'h00);
    settle();
    `CHK(pinSync, 8'h00)
    $display("test interrupts done");
    stop_test();
  end
endmodule : ppce_port_tb_top
